// file: rtl/core_store_pkg.sv
package core_store_pkg;
	localparam int DATA_W = 8;
	localparam int PLANES = 9;
	localparam int ADDR_W = 16;
	localparam int DEC_W = 13;
	localparam int MAIN_WORDS = 8192;
	localparam int HALF_WORDS = 4096;
	localparam int AUX_WORDS = 256;
	localparam int AUX_IDX_W = 8;
	localparam int HIGH_SEL_BIT = 12;
	localparam int HALF_SEL_BIT = 12;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TAP_NS = 25;
	localparam int SECTION_NS = 250;
	localparam int CHAIN_NS = 1500;
	localparam int TAPS_PER_SECTION = SECTION_NS / TAP_NS;
	localparam int CHAIN_TAPS = CHAIN_NS / TAP_NS;
	localparam int TICK_CYCLES = (TAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] TAP_PW_END = 6'h04;
	localparam logic [5:0] TAP_STAGE2_SET = 6'h1D;
	localparam logic [5:0] TAP_STAGE2_END = 6'h22;
	localparam logic [5:0] TAP_READ_ON = 6'h02;
	localparam logic [5:0] TAP_READ_OFF = 6'h0E;
	localparam logic [5:0] TAP_SENSE = 6'h08;
	localparam logic [5:0] TAP_WRITE_ON = 6'h1E;
	localparam logic [5:0] TAP_WRITE_OFF = 6'h2A;
	localparam logic [5:0] TAP_LAST = 6'h3B;
	localparam logic [PLANES-1:0] PLANES_CLEAR = 9'h000;
endpackage

// file: rtl/core_store_if.sv
`timescale 1ns/10ps
interface core_store_if;
	logic read_req;
	logic write_req;
	logic aux_sel;
	logic [core_store_pkg::ADDR_W-1:0] addr;
	logic [core_store_pkg::PLANES-1:0] wdata;
	logic [core_store_pkg::PLANES-1:0] rdata;
	logic rdata_valid;
	logic ready;
	modport storage (input read_req, write_req, aux_sel, addr, wdata,
		output rdata, rdata_valid, ready);
	modport processor (output read_req, write_req, aux_sel, addr, wdata,
		input rdata, rdata_valid, ready);
endinterface

// file: rtl/core_storage_cycle_control.sv
`timescale 1ns/10ps
// Summary of operation
// (RULE1) each location: eight data plus parity
// (RULE2) write inhibits planes whose bit is zero
// (RULE3) plane split in two 4096 halves
// (RULE4) extra 512 aux: channel and local
// (RULE5) main-aux latch picks area for low addresses
// (RULE6) high address bit 3 picks local storage
// (RULE7) aux lines cross first-dimension decode only
// (RULE8) one aux driver only per aux access
// (RULE9) strictly one position per cycle
// (RULE10) processor holds address through cycle
// (RULE11) read fills data register, write stores it
// (RULE12) only requests start clock, runs complete
// (RULE13) six sections, ten 25 ns taps each
// (RULE14) pulse latches set and cleared at taps
// (RULE15) same chain steered to read or write
// (RULE16) reset clears first, third latch; sets second
// (RULE17) first and second latch drive chain
// (RULE18) third section end sets third latch
// (RULE19) read destroys data; restore with write
// (RULE20) 16-bit address, low 13 decoded
// (RULE21) counter ticks replace delay taps
// (RULE22) busy holds off requests, ready signals
module core_storage_cycle_control (
	input wire logic clk_in,
	input wire logic rst_b_in,
	core_store_if.storage bus,
	output logic clock_run_out,
	output logic read_pulse_out,
	output logic write_pulse_out,
	output logic [core_store_pkg::PLANES-1:0] inhibit_out,
	output logic [1:0] aux_drive_out
);
	localparam int HW = core_store_pkg::HALF_WORDS;
	localparam int AW = core_store_pkg::AUX_WORDS;
	localparam int PL = core_store_pkg::PLANES;
	logic [PL-1:0] half_lo [HW]; // RULE3
	logic [PL-1:0] half_hi [HW]; // RULE3
	logic [PL-1:0] aux_mem [2*AW]; // RULE4
	logic clock_start_latch_r;
	logic pulse_width_latch_r;
	logic second_stage_drive_latch_r;
	logic [5:0] tap_r;
	logic [1:0] tick_r;
	logic tick;
	logic is_write_r;
	logic area_aux_r;
	logic area_local_r;
	logic [core_store_pkg::DEC_W-1:0] main_idx_r;
	logic [core_store_pkg::AUX_IDX_W-1:0] aux_idx_r;
	logic [PL-1:0] data_r;
	logic [PL-1:0] rdata_r;
	logic rvalid_r;
	logic [PL-1:0] sensed;
	logic running;
	logic ready_r;
	// the chain advances while running is high: the start latch or the second-stage latch is set, or the tap count is nonzero
	assign running = clock_start_latch_r | second_stage_drive_latch_r | (tap_r != 6'h00);
	assign tick = running && (tick_r == 2'(core_store_pkg::TICK_CYCLES - 1)); // RULE21
	// tick divider: one enable every 3 clocks (30 ns), standing for one 25 ns tap
	always_ff @(posedge clk_in) begin
		if (!rst_b_in || !running) begin
			tick_r <= 2'h0;
		end else if (tick) begin
			tick_r <= 2'h0;
		end else begin
			tick_r <= tick_r + 2'h1;
		end
	end
	// tap counter stands for the 60-tap chain
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			tap_r <= 6'h00;
		end else if (tick) begin
			if (tap_r == core_store_pkg::TAP_LAST) begin // RULE13
				tap_r <= 6'h00;
			end else begin
				tap_r <= tap_r + 6'h01;
			end
		end
	end
	// control latches; the start is accepted only when idle
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			clock_start_latch_r <= 1'b0; // RULE16
			pulse_width_latch_r <= 1'b1; // RULE16
			second_stage_drive_latch_r <= 1'b0; // RULE16
		end else begin
			if (!running && (bus.read_req || bus.write_req)) begin
				clock_start_latch_r <= 1'b1; // RULE12 RULE17 RULE22
			end else if (!pulse_width_latch_r) begin
				clock_start_latch_r <= 1'b0; // RULE17
			end
			if (!clock_start_latch_r) begin
				pulse_width_latch_r <= 1'b1; // RULE17
			end else if (tick && tap_r == core_store_pkg::TAP_PW_END) begin
				pulse_width_latch_r <= 1'b0; // RULE17
			end
			if (tick && tap_r == core_store_pkg::TAP_STAGE2_SET) begin
				second_stage_drive_latch_r <= 1'b1; // RULE18
			end else if (tick && tap_r == core_store_pkg::TAP_STAGE2_END) begin
				second_stage_drive_latch_r <= 1'b0; // RULE18
			end
		end
	end
	// request capture: address is also held by the processor, latched anyway
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			is_write_r <= 1'b0;
			area_aux_r <= 1'b0;
			area_local_r <= 1'b0;
			main_idx_r <= '0;
			aux_idx_r <= '0;
			data_r <= core_store_pkg::PLANES_CLEAR;
		end else if (!running && (bus.read_req || bus.write_req)) begin
			is_write_r <= bus.write_req; // RULE15
			// the latch alone picks main or aux; an aux access decodes only the low eight
			// bits and the area select bit, the rest of the address is ignored
			area_aux_r <= bus.aux_sel; // RULE5
			area_local_r <= bus.addr[core_store_pkg::HIGH_SEL_BIT]; // RULE6
			main_idx_r <= bus.addr[core_store_pkg::DEC_W-1:0]; // RULE20 RULE10
			aux_idx_r <= bus.addr[core_store_pkg::AUX_IDX_W-1:0]; // RULE7
			data_r <= bus.wdata; // RULE11
		end
	end
	// read/write pulse latches set and cleared at taps
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			read_pulse_out <= 1'b0;
			write_pulse_out <= 1'b0;
		end else if (tick) begin
			if (tap_r == core_store_pkg::TAP_READ_ON && !is_write_r) begin
				read_pulse_out <= 1'b1; // RULE14 RULE15
			end else if (tap_r == core_store_pkg::TAP_READ_OFF) begin
				read_pulse_out <= 1'b0; // RULE14
			end
			if (tap_r == core_store_pkg::TAP_WRITE_ON && is_write_r) begin
				write_pulse_out <= 1'b1; // RULE14 RULE15
			end else if (tap_r == core_store_pkg::TAP_WRITE_OFF) begin
				write_pulse_out <= 1'b0; // RULE14
			end
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			clock_run_out <= 1'b0;
			aux_drive_out <= 2'h0;
			inhibit_out <= core_store_pkg::PLANES_CLEAR;
		end else begin
			clock_run_out <= running;
			// at most one aux driver: bit0 channel area, bit1 local area
			aux_drive_out <= (running && area_aux_r) ?
				(area_local_r ? 2'h2 : 2'h1) : 2'h0; // RULE8
			inhibit_out <= (running && is_write_r) ? ~data_r : core_store_pkg::PLANES_CLEAR; // RULE2
		end
	end
	always_comb begin
		if (area_aux_r) begin
			sensed = aux_mem[{area_local_r, aux_idx_r}];
		end else if (main_idx_r[core_store_pkg::HALF_SEL_BIT]) begin
			sensed = half_hi[main_idx_r[core_store_pkg::HALF_SEL_BIT-1:0]]; // RULE3
		end else begin
			sensed = half_lo[main_idx_r[core_store_pkg::HALF_SEL_BIT-1:0]];
		end
	end
	// no reset on the arrays: cores keep their contents through a machine reset
	// core array: the read clears the position (destructive), the write sets one-bits
	always_ff @(posedge clk_in) begin
		if (tick && tap_r == core_store_pkg::TAP_SENSE && !is_write_r) begin
			if (area_aux_r) begin
				aux_mem[{area_local_r, aux_idx_r}] <= core_store_pkg::PLANES_CLEAR; // RULE19
			end else if (main_idx_r[core_store_pkg::HALF_SEL_BIT]) begin
				half_hi[main_idx_r[core_store_pkg::HALF_SEL_BIT-1:0]] <= core_store_pkg::PLANES_CLEAR;
			end else begin
				half_lo[main_idx_r[core_store_pkg::HALF_SEL_BIT-1:0]] <= core_store_pkg::PLANES_CLEAR;
			end
		end else if (tick && tap_r == core_store_pkg::TAP_WRITE_ON && is_write_r) begin
			if (area_aux_r) begin
				aux_mem[{area_local_r, aux_idx_r}] <= sensed | data_r; // RULE1 RULE9
			end else if (main_idx_r[core_store_pkg::HALF_SEL_BIT]) begin
				half_hi[main_idx_r[core_store_pkg::HALF_SEL_BIT-1:0]] <= sensed | data_r;
			end else begin
				half_lo[main_idx_r[core_store_pkg::HALF_SEL_BIT-1:0]] <= sensed | data_r;
			end
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			rdata_r <= core_store_pkg::PLANES_CLEAR;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= tick && tap_r == core_store_pkg::TAP_SENSE && !is_write_r;
			if (tick && tap_r == core_store_pkg::TAP_SENSE && !is_write_r) begin
				rdata_r <= sensed; // RULE9 RULE11
			end
		end
	end
	assign bus.rdata = rdata_r;
	assign bus.rdata_valid = rvalid_r;
	// registered so the port comes straight from a flop: it falls on the edge that
	// takes a request and rises one cycle after the chain has stopped
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			ready_r <= 1'b1;
		end else begin
			ready_r <= !running && !(bus.read_req || bus.write_req); // RULE22
		end
	end
	assign bus.ready = ready_r; // RULE22
endmodule // core_storage_cycle_control

// file: rtl/core_store_processor.sv
`timescale 1ns/10ps
// processor end: holds address and data registers, issues one-cycle requests
module core_store_processor (
	input wire logic clk_in,
	input wire logic rst_b_in,
	core_store_if.processor bus,
	input wire logic read_cmd_in,
	input wire logic write_cmd_in,
	input wire logic aux_cmd_in,
	input wire logic [core_store_pkg::ADDR_W-1:0] addr_in,
	input wire logic [core_store_pkg::PLANES-1:0] data_in,
	output logic [core_store_pkg::PLANES-1:0] data_out,
	output logic busy_out
);
	logic read_req_r;
	logic write_req_r;
	logic main_aux_latch_r;
	logic [core_store_pkg::ADDR_W-1:0] addr_r;
	logic [core_store_pkg::PLANES-1:0] data_r;
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			read_req_r <= 1'b0;
			write_req_r <= 1'b0;
			main_aux_latch_r <= 1'b0;
			addr_r <= '0;
			busy_out <= 1'b0;
		end else begin
			read_req_r <= 1'b0;
			write_req_r <= 1'b0;
			if (busy_out) begin
				// address stays put until the storage is ready again
				busy_out <= !bus.ready || read_req_r || write_req_r; // RULE10
			end else if (bus.ready && (read_cmd_in || write_cmd_in)) begin
				read_req_r <= read_cmd_in;
				write_req_r <= write_cmd_in && !read_cmd_in;
				main_aux_latch_r <= aux_cmd_in; // RULE5 RULE6
				addr_r <= addr_in; // RULE10
				busy_out <= 1'b1;
			end
		end
	end
	// data register: loaded by software, overwritten by a read
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			data_r <= core_store_pkg::PLANES_CLEAR;
		end else if (bus.rdata_valid) begin
			data_r <= bus.rdata; // RULE11
		end else if (!busy_out && write_cmd_in && !read_cmd_in) begin
			data_r <= data_in; // RULE11
		end
	end
	assign data_out = data_r;
	assign bus.read_req = read_req_r;
	assign bus.write_req = write_req_r;
	assign bus.aux_sel = main_aux_latch_r;
	assign bus.addr = addr_r;
	assign bus.wdata = data_r;
endmodule // core_store_processor

// file: tb/core_storage_cycle_control_properties.sv
`timescale 1ns/10ps
module core_storage_cycle_control_properties (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic read_req_in,
	input wire logic write_req_in,
	input wire logic aux_sel_in,
	input wire logic [core_store_pkg::ADDR_W-1:0] addr_in,
	input wire logic [core_store_pkg::PLANES-1:0] wdata_in,
	input wire logic [core_store_pkg::PLANES-1:0] rdata_in,
	input wire logic rdata_valid_in,
	input wire logic ready_in
);
	// a cycle is the whole chain at one tick per tap; ready trails it by a register or so
	localparam int CHAIN_CYCLES = core_store_pkg::CHAIN_TAPS * core_store_pkg::TICK_CYCLES;
	localparam int CHAIN_SLACK = CHAIN_CYCLES + 2;
	logic [8:0] low_cnt_r;
	logic wr_cycle_r;
	// sampled cycles with ready low; a hang runs past the slack long before wrapping
	always_ff @(posedge clk_in) begin
		if (!rst_b_in || ready_in) begin
			low_cnt_r <= 9'h000;
		end else begin
			low_cnt_r <= low_cnt_r + 9'h001;
		end
	end
	// remembers whether the running cycle is a write
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			wr_cycle_r <= 1'b0;
		end else if (read_req_in || write_req_in) begin
			wr_cycle_r <= write_req_in;
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	sequence s_take;
		(read_req_in || write_req_in) && ready_in;
	endsequence
	// ready stays low for at least eight cycles once it falls
	sequence s_run;
		!ready_in [*8];
	endsequence
	a_one_kind: assert property (!(read_req_in && write_req_in))
		else $error("read and write requested together");
	a_req_idle: assert property ((read_req_in || write_req_in) |-> ready_in)
		else $error("request while running");
	a_busy_after: assert property (s_take |-> ##[1:2] !ready_in)
		else $error("ready stayed high after request");
	a_cycle_len: assert property ($fell(ready_in) |-> s_run)
		else $error("storage cycle ended early");
	a_cycle_end: assert property ($rose(ready_in) |-> low_cnt_r >= CHAIN_CYCLES && low_cnt_r <= CHAIN_SLACK)
		else $error("storage cycle length wrong");
	a_no_hang: assert property (low_cnt_r <= CHAIN_SLACK)
		else $error("storage cycle never ended");
	a_addr_held: assert property (!ready_in |-> $stable(addr_in) && $stable(aux_sel_in))
		else $error("address moved during cycle");
	a_data_held: assert property (wr_cycle_r && !ready_in |-> $stable(wdata_in))
		else $error("write byte moved during write cycle");
	a_rdata_stands: assert property (!$stable(rdata_in) |-> rdata_valid_in)
		else $error("read byte changed without valid");
	a_valid_inside: assert property (rdata_valid_in |-> !ready_in)
		else $error("read byte outside a cycle");
	a_valid_once: assert property (rdata_valid_in |=> !rdata_valid_in)
		else $error("read valid longer than one cycle");
	a_read_answer: assert property (read_req_in && ready_in |-> ##[10:40] rdata_valid_in)
		else $error("read answer missing");
endmodule // core_storage_cycle_control_properties

// file: tb/tb_core_storage_cycle_control.sv
`timescale 1ns/10ps
module tb_core_storage_cycle_control;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic rd_cmd = 1'b0;
	logic wr_cmd = 1'b0;
	logic aux_cmd = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [8:0] data = 9'h000;
	logic [8:0] data_out;
	logic [8:0] inhibit;
	logic busy;
	logic run;
	logic rpulse;
	logic wpulse;
	logic [1:0] drive;
	int fail_count = 0;
	int checks_done = 0;
	core_store_if bus();
	core_storage_cycle_control core_storage_cycle_control_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.bus(bus), .clock_run_out(run), .read_pulse_out(rpulse), .write_pulse_out(wpulse),
		.inhibit_out(inhibit), .aux_drive_out(drive));
	core_store_processor core_store_processor_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus(bus),
		.read_cmd_in(rd_cmd), .write_cmd_in(wr_cmd), .aux_cmd_in(aux_cmd), .addr_in(addr),
		.data_in(data), .data_out(data_out), .busy_out(busy));
	core_storage_cycle_control_properties core_storage_cycle_control_properties_i (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .read_req_in(bus.read_req),
		.write_req_in(bus.write_req), .aux_sel_in(bus.aux_sel), .addr_in(bus.addr),
		.wdata_in(bus.wdata), .rdata_in(bus.rdata), .rdata_valid_in(bus.rdata_valid),
		.ready_in(bus.ready));
	always #5 clk_in = ~clk_in;
	task check(input logic [8:0] seen, input logic [8:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// one full storage cycle; pulses are judged the first time they stand
	task op(input logic w, input logic a, input logic [15:0] ad, input logic [8:0] d,
		input logic [1:0] drv);
		int n;
		bit seen_p;
		bit seen_w;
		int hi;
		int span;
		n = 0;
		hi = 0;
		seen_p = 0;
		seen_w = 0;
		@(posedge clk_in);
		rd_cmd <= !w;
		wr_cmd <= w;
		aux_cmd <= a;
		addr <= ad;
		data <= d;
		@(posedge clk_in);
		rd_cmd <= 1'b0;
		wr_cmd <= 1'b0;
		do begin
			@(posedge clk_in);
			#1;
			n++;
			if (rpulse === 1'b1 || wpulse === 1'b1) begin
				hi++;
			end
			if ((rpulse === 1'b1 || wpulse === 1'b1) && !seen_p) begin
				check({7'h00, drive}, {7'h00, drv});
				if (w == 1'b0) begin
					check(inhibit, core_store_pkg::PLANES_CLEAR);
				end
				check({8'h00, run}, 9'h001);
				seen_p = 1;
			end
			if (wpulse === 1'b1 && !seen_w) begin
				check(inhibit, ~d);
				seen_w = 1;
			end
		end while ((busy !== 1'b0 || bus.ready !== 1'b1) && n < 400);
		if (w) begin
			span = core_store_pkg::TAP_WRITE_OFF - core_store_pkg::TAP_WRITE_ON;
		end else begin
			span = core_store_pkg::TAP_READ_OFF - core_store_pkg::TAP_READ_ON;
		end
		check(9'(hi), 9'(span * core_store_pkg::TICK_CYCLES));
		check({4'h0, run, rpulse, wpulse, drive}, 9'h000);
		check(inhibit, core_store_pkg::PLANES_CLEAR);
		check({8'h00, seen_p}, 9'h001);
		check({8'h00, seen_w}, {8'h00, w});
		check({8'h00, n < 400}, 9'h001);
	endtask
	task rd(input logic a, input logic [15:0] ad, input logic [1:0] drv, input logic [8:0] exp);
		op(1'b0, a, ad, 9'h000, drv);
		check(data_out, exp);
	endtask
	task test_destructive;
		op(1'b0, 1'b0, 16'h0040, 9'h000, 2'b00);
		op(1'b1, 1'b0, 16'h0040, 9'h1A5, 2'b00);
		rd(1'b0, 16'h0040, 2'b00, 9'h1A5);
		rd(1'b0, 16'h0040, 2'b00, 9'h000);
		op(1'b1, 1'b0, 16'h0040, 9'h1A5, 2'b00);
		op(1'b1, 1'b0, 16'h0040, 9'h052, 2'b00);
		rd(1'b0, 16'h0040, 2'b00, 9'h1F7);
		$display("destructive read test ended");
	endtask
	// same low address in main, channel and local areas must stay apart
	task test_areas;
		logic [15:0] ad;
		for (int i = 0; i < 3; i++) begin
			ad = (i == 2) ? 16'h10AE : 16'h00AE;
			op(1'b0, i != 0, ad, 9'h000, 2'(i));
			op(1'b1, i != 0, ad, 9'h150 + 9'(i), 2'(i));
		end
		for (int i = 0; i < 3; i++) begin
			ad = (i == 2) ? 16'h10AE : 16'h00AE;
			rd(i != 0, ad, 2'(i), 9'h150 + 9'(i));
		end
		$display("area select test ended");
	endtask
	task test_alias;
		op(1'b0, 1'b0, 16'h0123, 9'h000, 2'b00);
		op(1'b1, 1'b0, 16'hE123, 9'h0C3, 2'b00);
		rd(1'b0, 16'h0123, 2'b00, 9'h0C3);
		$display("address width test ended");
	endtask
	// reset in mid-pulse must leave the clock idle and ready for a fresh start
	task test_reset;
		@(posedge clk_in);
		rd_cmd <= 1'b1;
		aux_cmd <= 1'b0;
		addr <= 16'h0077;
		@(posedge clk_in);
		rd_cmd <= 1'b0;
		repeat (20) @(posedge clk_in);
		rst_b_in <= 1'b0;
		#1;
		check({8'h00, rpulse}, 9'h001);
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		#1;
		check({4'h0, run, rpulse, wpulse, drive}, 9'h000);
		check({7'h00, busy, bus.ready}, 9'h001);
		op(1'b0, 1'b0, 16'h0077, 9'h000, 2'b00);
		op(1'b1, 1'b0, 16'h0077, 9'h12C, 2'b00);
		rd(1'b0, 16'h0077, 2'b00, 9'h12C);
		$display("mid-cycle reset test ended");
	endtask
	initial begin
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		test_destructive;
		test_areas;
		test_alias;
		test_reset;
		test_done;
	end
	// about 23 storage cycles of 185 clocks are expected; allow several times that
	initial begin
		#200000;
		fail_count++;
		test_done;
	end
endmodule // tb_core_storage_cycle_control
